// ### pch_config_regs.sv
`timescale 1ns/10ps
// Contract
// (RULE1) Cache line byte always reads zero
// (RULE2) Latency byte writable, resets zero, exported
// (RULE3) Self test byte always reads zero
// (RULE4) Interrupt routing byte plain read/write storage
// (RULE5) Interrupt pin byte constant one
// (RULE6) Grant and interval bytes constant 08h, 38h
// (RULE7) Offset 10h: 4 KB prefetchable memory
// (RULE8) Offset 14h: 32-byte I/O window
// (RULE9) Offset 18h: 1 MB non-prefetchable memory
// (RULE10) Offsets 1Ch-27h read zero, ignore writes
// (RULE11) 1 MB window: only top 12 writable
// (RULE12) Both control windows always requested
// (RULE13) Boot ROM window register at 30h
// (RULE14) ROM upper 21 bits hold address
// (RULE15) ROM top 12 bits writable, 1 MB
// (RULE16) ROM enable bit0, gated by memory space
// (RULE17) Bit0 zero memory, one I/O
// (RULE18) All-ones write returns size mask
module pch_config_regs
    import pch_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Configuration access, already decoded
    input wire pch_req_s req,
    input wire logic mem_space_en,
    // Read answer
    output logic [31:0] rdata,
    output logic rvalid,
    // Values used by the rest of the device
    output logic [7:0] burst_latency_timer,
    output logic [7:0] interrupt_routing,
    output pch_bars_s bars,
    output logic rom_decode_active
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] lat;
        logic [7:0] introute;
        logic [31:0] rdata;
        logic rvalid;
        pch_bars_s bars;
        logic rom_act;
        pch_phase_e phase;
    } pch_state_s;

    pch_state_s st_q;
    pch_state_s st_d;
    logic [7:0] byte_addr;
    logic [31:0] v_mem;
    logic [31:0] v_io;
    logic [31:0] v_flash;
    logic [31:0] v_rom;
    logic wr_mem;
    logic wr_io;
    logic wr_flash;
    logic wr_rom;

    assign byte_addr = {req.dword, 2'b00};

    // ****************************************
    // Window registers
    // ****************************************
    // Address decode per window; reserved span has no write strobe (RULE10)
    assign wr_mem = req.wr && (byte_addr == PCH_OFF_CSR_MEM);
    assign wr_io = req.wr && (byte_addr == PCH_OFF_CSR_IO);
    assign wr_flash = req.wr && (byte_addr == PCH_OFF_FLASH);
    assign wr_rom = req.wr && (byte_addr == PCH_OFF_ROM);

    // Control memory window, prefetchable (RULE7) (RULE12) (RULE17) (RULE18)
    pch_bar_reg #(.MASK(PCH_MASK_CSR_MEM), .FIXED(PCH_TYPE_CSR_MEM), .RW_LOW(32'h0000_0000)) u_csr_mem (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .wr(wr_mem),
        .be(req.be),
        .wdata(req.wdata),
        .value(v_mem)
    );

    // Control I/O window; bit1 reads zero (RULE8) (RULE12) (RULE17) (RULE18)
    pch_bar_reg #(.MASK(PCH_MASK_CSR_IO), .FIXED(PCH_TYPE_CSR_IO), .RW_LOW(32'h0000_0000)) u_csr_io (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .wr(wr_io),
        .be(req.be),
        .wdata(req.wdata),
        .value(v_io)
    );

    // Flash buffer, top 12 bits only (RULE9) (RULE11) (RULE17) (RULE18)
    pch_bar_reg #(.MASK(PCH_MASK_FLASH), .FIXED(PCH_TYPE_FLASH), .RW_LOW(32'h0000_0000)) u_flash (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .wr(wr_flash),
        .be(req.be),
        .wdata(req.wdata),
        .value(v_flash)
    );

    // Boot ROM window with enable in bit0 (RULE13) (RULE14) (RULE15) (RULE16) (RULE18)
    pch_bar_reg #(.MASK(PCH_MASK_ROM), .FIXED(32'h0000_0000), .RW_LOW(32'h0000_0001)) u_rom (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .wr(wr_rom),
        .be(req.be),
        .wdata(req.wdata),
        .value(v_rom)
    );

    // ****************************************
    // Byte registers and read mux
    // ****************************************
    // Reads answer one cycle later from a register
    always_comb begin
        st_d = st_q;
        st_d.rvalid = req.rd;
        st_d.phase = req.rd ? PCH_DONE : PCH_IDLE;
        st_d.bars = '{csr_mem: v_mem, csr_io: v_io, flash: v_flash, rom: v_rom};
        // Memory space bit takes precedence over the enable (RULE16)
        st_d.rom_act = v_rom[PCH_ROM_EN_BIT] && mem_space_en;
        if (req.wr && byte_addr == PCH_OFF_MISC0 && req.be[PCH_LANE_LAT]) begin
            st_d.lat = req.wdata[15:8]; // RULE2
        end
        if (req.wr && byte_addr == PCH_OFF_MISC3 && req.be[PCH_LANE_INTROUTE]) begin
            st_d.introute = req.wdata[7:0]; // RULE4
        end
        if (req.rd) begin
            unique case (byte_addr)
                PCH_OFF_MISC0: begin
                    // Cache line and self test are fixed (RULE1) (RULE3)
                    st_d.rdata = {PCH_SELFTEST_VAL, 8'h00, st_q.lat, PCH_CACHE_LINE_VAL};
                end
                PCH_OFF_CSR_MEM: begin
                    st_d.rdata = v_mem;
                end
                PCH_OFF_CSR_IO: begin
                    st_d.rdata = v_io;
                end
                PCH_OFF_FLASH: begin
                    st_d.rdata = v_flash;
                end
                PCH_OFF_ROM: begin
                    st_d.rdata = v_rom;
                end
                PCH_OFF_MISC3: begin
                    // Pin, grant, interval constants (RULE5) (RULE6)
                    st_d.rdata = {PCH_INTERVAL_VAL, PCH_GRANT_VAL, PCH_INTPIN_VAL, st_q.introute};
                end
                default: begin
                    // Reserved span and all else read zero (RULE10)
                    st_d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q.lat <= PCH_LAT_RST;
            st_q.introute <= PCH_INTROUTE_RST;
            st_q.rdata <= 32'h0000_0000;
            st_q.rvalid <= 1'b0;
            st_q.bars <= '0;
            st_q.rom_act <= 1'b0;
            st_q.phase <= PCH_IDLE;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdata = st_q.rdata;
    assign rvalid = st_q.rvalid;
    assign burst_latency_timer = st_q.lat;
    assign interrupt_routing = st_q.introute;
    assign bars = st_q.bars;
    assign rom_decode_active = st_q.rom_act;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_read_misc0;
        req.rd && ce && byte_addr == PCH_OFF_MISC0;
    endsequence

    sequence s_read_misc3;
        req.rd && ce && byte_addr == PCH_OFF_MISC3;
    endsequence

    cache_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
        s_read_misc0 |=> rdata[7:0] == 8'h00 && rdata[31:24] == 8'h00)
        else $error("cache line or self test byte not zero");

    latency_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
        (req.wr && ce && byte_addr == PCH_OFF_MISC0 && req.be[1]) |=> burst_latency_timer == $past(req.wdata[15:8]))
        else $error("latency byte not stored");

    routing_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
        (req.wr && ce && byte_addr == PCH_OFF_MISC3 && req.be[0]) |=> interrupt_routing == $past(req.wdata[7:0]))
        else $error("routing byte not stored");

    pin_grant_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
        s_read_misc3 |=> rdata[31:8] == 24'h38_08_01)
        else $error("pin, grant or interval constant wrong");

    bar_low_bits_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE17
        v_mem[11:0] == 12'h008 && v_io[4:0] == 5'h01 && v_flash[19:0] == 20'h00000)
        else $error("window low bits wrong");

    reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE10
        (req.rd && ce && byte_addr >= PCH_OFF_RSVD_LO && byte_addr <= PCH_OFF_RSVD_HI) |=> rdata == 32'h0)
        else $error("reserved read not zero");

    size_probe_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE18
        (wr_flash && ce && req.be == 4'hF && req.wdata == 32'hFFFF_FFFF) |=> v_flash == PCH_MASK_FLASH)
        else $error("flash window sizing wrong");

    rom_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE16
        ce |=> rom_decode_active == ($past(v_rom[0]) && $past(mem_space_en)))
        else $error("rom decode gating wrong");

    read_answer_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE13
        (req.rd && ce && byte_addr == PCH_OFF_ROM) |=> rvalid && rdata == $past(v_rom))
        else $error("rom register read wrong");

    // ****************************************
    // Read handshake and freeze checks
    // ****************************************
    sequence s_read_any;
        req.rd && ce;
    endsequence

    sequence s_idle_step;
        ce && !req.rd;
    endsequence

    // Every taken read is answered once, one cycle later
    read_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE18
        s_read_any |=> rvalid)
        else $error("read not answered");

    // Data must stand until the next read, or software sees it move
    answer_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE18
        s_idle_step |=> !rvalid && $stable(rdata))
        else $error("read answer repeated or moved");

    // Enable low parks every visible value
    freeze_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
        !ce |=> $stable(rdata) && $stable(rvalid) && $stable(bars) && $stable(burst_latency_timer)
            && $stable(interrupt_routing) && $stable(rom_decode_active))
        else $error("state moved while frozen");

    // Exported windows trail the live registers by one cycle
    bars_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE12
        ce |=> bars.csr_mem == $past(v_mem) && bars.csr_io == $past(v_io)
            && bars.flash == $past(v_flash) && bars.rom == $past(v_rom))
        else $error("exported windows out of step");

    // ****************************************
    // Window write and read checks
    // ****************************************
    sequence s_read_mem;
        req.rd && ce && byte_addr == PCH_OFF_CSR_MEM;
    endsequence

    sequence s_read_io;
        req.rd && ce && byte_addr == PCH_OFF_CSR_IO;
    endsequence

    sequence s_read_flash;
        req.rd && ce && byte_addr == PCH_OFF_FLASH;
    endsequence

    sequence s_write_rsvd;
        req.wr && ce && byte_addr >= PCH_OFF_RSVD_LO && byte_addr <= PCH_OFF_RSVD_HI;
    endsequence

    // Full-dword writes keep only the writable bits and the type code
    mem_merge_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
        (wr_mem && ce && req.be == 4'hF)
            |=> v_mem == (($past(req.wdata) & PCH_MASK_CSR_MEM) | PCH_TYPE_CSR_MEM))
        else $error("memory window write wrong");

    io_merge_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
        (wr_io && ce && req.be == 4'hF)
            |=> v_io == (($past(req.wdata) & PCH_MASK_CSR_IO) | PCH_TYPE_CSR_IO))
        else $error("io window write wrong");

    rom_merge_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE15
        (wr_rom && ce && req.be == 4'hF)
            |=> v_rom == ($past(req.wdata) & (PCH_MASK_ROM | 32'h0000_0001)))
        else $error("rom window write wrong");

    // Reserved span has no storage behind it
    rsvd_ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE10
        s_write_rsvd |=> $stable(v_mem) && $stable(v_io) && $stable(v_flash) && $stable(v_rom)
            && $stable(burst_latency_timer) && $stable(interrupt_routing))
        else $error("reserved write changed state");

    // Reads return the live register value
    mem_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
        s_read_mem |=> rdata == $past(v_mem))
        else $error("memory window read wrong");

    io_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
        s_read_io |=> rdata == $past(v_io))
        else $error("io window read wrong");

    flash_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE9
        s_read_flash |=> rdata == $past(v_flash))
        else $error("flash window read wrong");

    // ****************************************
    // Byte register checks
    // ****************************************
    sequence s_lat_write;
        req.wr && ce && byte_addr == PCH_OFF_MISC0 && req.be[PCH_LANE_LAT];
    endsequence

    sequence s_route_write;
        req.wr && ce && byte_addr == PCH_OFF_MISC3 && req.be[PCH_LANE_INTROUTE];
    endsequence

    sequence s_no_write;
        !req.wr;
    endsequence

    // Lanes not enabled must not touch the stored byte
    lat_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
        (req.wr && ce && byte_addr == PCH_OFF_MISC0 && !req.be[PCH_LANE_LAT]) |=> $stable(burst_latency_timer))
        else $error("latency byte changed by disabled lane");

    route_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
        (req.wr && ce && byte_addr == PCH_OFF_MISC3 && !req.be[PCH_LANE_INTROUTE]) |=> $stable(interrupt_routing))
        else $error("routing byte changed by disabled lane");

    lat_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
        s_read_misc0 |=> rdata[15:8] == $past(burst_latency_timer) && rdata[23:16] == 8'h00)
        else $error("latency byte read wrong");

    route_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
        s_read_misc3 |=> rdata[7:0] == $past(interrupt_routing))
        else $error("routing byte read wrong");

    // Write, a quiet cycle, then a read must return what was written
    lat_loop_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
        s_lat_write ##1 s_no_write ##1 s_read_misc0 |=> rdata[15:8] == $past(req.wdata[15:8], 3))
        else $error("latency byte lost between write and read");

    route_loop_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
        s_route_write ##1 s_no_write ##1 s_read_misc3 |=> rdata[7:0] == $past(req.wdata[7:0], 3))
        else $error("routing byte lost between write and read");

endmodule : pch_config_regs

// ### pch_pkg.sv
package pch_pkg;

    // ****************************************
    // Configuration header offsets (dword)
    // ****************************************
    localparam logic [7:0] PCH_OFF_MISC0 = 8'h0C; // Cache line, latency, self test
    localparam logic [7:0] PCH_OFF_CSR_MEM = 8'h10;
    localparam logic [7:0] PCH_OFF_CSR_IO = 8'h14;
    localparam logic [7:0] PCH_OFF_FLASH = 8'h18;
    localparam logic [7:0] PCH_OFF_RSVD_LO = 8'h1C;
    localparam logic [7:0] PCH_OFF_RSVD_HI = 8'h27;
    localparam logic [7:0] PCH_OFF_ROM = 8'h30;
    localparam logic [7:0] PCH_OFF_MISC3 = 8'h3C; // Int routing, pin, grant, interval

    // ****************************************
    // Byte lanes inside the dwords
    // ****************************************
    localparam int PCH_LANE_CACHE = 0;
    localparam int PCH_LANE_LAT = 1;
    localparam int PCH_LANE_SELFTEST = 3;
    localparam int PCH_LANE_INTROUTE = 0;
    localparam int PCH_LANE_INTPIN = 1;
    localparam int PCH_LANE_GRANT = 2;
    localparam int PCH_LANE_INTERVAL = 3;

    // ****************************************
    // Constant and reset values
    // ****************************************
    localparam logic [7:0] PCH_CACHE_LINE_VAL = 8'h00;
    localparam logic [7:0] PCH_SELFTEST_VAL = 8'h00;
    localparam logic [7:0] PCH_INTPIN_VAL = 8'h01;
    localparam logic [7:0] PCH_GRANT_VAL = 8'h08;
    localparam logic [7:0] PCH_INTERVAL_VAL = 8'h38;
    localparam logic [7:0] PCH_LAT_RST = 8'h00;
    localparam logic [7:0] PCH_INTROUTE_RST = 8'h00;

    // ****************************************
    // Window masks: ones mark writable bits
    // ****************************************
    localparam logic [31:0] PCH_MASK_CSR_MEM = 32'hFFFF_F000; // 4 KB
    localparam logic [31:0] PCH_MASK_CSR_IO = 32'hFFFF_FFE0; // 32 B
    localparam logic [31:0] PCH_MASK_FLASH = 32'hFFF0_0000; // 1 MB
    localparam logic [31:0] PCH_MASK_ROM = 32'hFFF0_0000; // 1 MB
    localparam logic [31:0] PCH_TYPE_CSR_MEM = 32'h0000_0008; // Memory, prefetchable
    localparam logic [31:0] PCH_TYPE_CSR_IO = 32'h0000_0001; // I/O indicator
    localparam logic [31:0] PCH_TYPE_FLASH = 32'h0000_0000; // Memory, not prefetchable
    localparam int PCH_ROM_EN_BIT = 0;
    localparam int PCH_ROM_ADDR_LSB = 11; // Upper 21 bits hold the address

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] dword;
        logic [3:0] be;
        logic [31:0] wdata;
    } pch_req_s;

    typedef struct packed {
        logic [31:0] csr_mem;
        logic [31:0] csr_io;
        logic [31:0] flash;
        logic [31:0] rom;
    } pch_bars_s;

    typedef enum logic [1:0] {
        PCH_IDLE = 2'b01,
        PCH_DONE = 2'b10
    } pch_phase_e;

endpackage : pch_pkg

// ### pch_bar_reg.sv
`timescale 1ns/10ps
// One base window register: writable bits by mask, fixed low bits
module pch_bar_reg
    import pch_pkg::*;
#(
    parameter logic [31:0] MASK = 32'hFFF0_0000,
    parameter logic [31:0] FIXED = 32'h0000_0000,
    parameter logic [31:0] RW_LOW = 32'h0000_0000
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Write access
    input wire logic wr,
    input wire logic [3:0] be,
    input wire logic [31:0] wdata,
    // Value
    output logic [31:0] value
);
    typedef struct packed {
        logic [31:0] store;
    } pch_bar_state_s;

    pch_bar_state_s st_q;
    pch_bar_state_s st_d;
    logic [31:0] lane;

    // Byte merge; only writable bits ever store ones
    always_comb begin
        st_d = st_q;
        lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        if (wr) begin
            st_d.store = ((wdata & lane) | (st_q.store & ~lane)) & (MASK | RW_LOW);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // Sizing read-back comes out through the mask
    assign value = st_q.store | FIXED;

endmodule : pch_bar_reg

// ### pch_host_model.sv
`timescale 1ns/10ps
// ****
// Host bridge model
// ****
// Software side: sets latency and routing, picks a window
module pch_host_model
    import pch_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Access and answer
    output pch_req_s req,
    input wire logic [31:0] rdata,
    input wire logic rvalid
);
    // Idle request at time zero
    initial begin
        req = '0;
    end

    // One write, strobe held across exactly one edge
    task automatic cfg_write(input logic [7:0] off, input logic [3:0] ben, input logic [31:0] d);
        @(posedge clk_sys);
        #1;
        req = '{rd: 1'b0, wr: 1'b1, dword: off[7:2], be: ben, wdata: d};
        @(posedge clk_sys);
        #1;
        req.wr = 1'b0;
        req.wdata = ~d; // Released data must not look valid
    endtask : cfg_write

    // One read; answer awaited a few cycles only, so a hang shows
    task automatic cfg_read(input logic [7:0] off, output logic [31:0] d);
        int n;
        @(posedge clk_sys);
        #1;
        req.rd = 1'b1;
        req.dword = off[7:2];
        @(posedge clk_sys);
        #1;
        req.rd = 1'b0;
        n = 0;
        while (rvalid !== 1'b1 && n < 4) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        d = (rvalid === 1'b1) ? rdata : 32'hX;
    endtask : cfg_read
endmodule : pch_host_model

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import pch_pkg::*;
    logic clk_sys;
    logic rst_n;
    logic ce;
    logic mem_space_en;
    pch_req_s req;
    logic [31:0] rdata;
    logic rvalid;
    logic [7:0] burst_latency_timer;
    logic [7:0] interrupt_routing;
    pch_bars_s bars;
    logic rom_decode_active;
    int failures;
    int total_checks;

    pch_config_regs i_pch_config_regs (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .req(req),
        .mem_space_en(mem_space_en), .rdata(rdata), .rvalid(rvalid),
        .burst_latency_timer(burst_latency_timer), .interrupt_routing(interrupt_routing),
        .bars(bars), .rom_decode_active(rom_decode_active));
    pch_host_model i_pch_host_model (.clk_sys(clk_sys), .req(req), .rdata(rdata), .rvalid(rvalid));

    // ****
    // Helpers
    // ****
    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] off, input logic [3:0] ben, input logic [31:0] d);
        i_pch_host_model.cfg_write(off, ben, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] off, input logic [31:0] exp);
        logic [31:0] v;
        i_pch_host_model.cfg_read(off, v);
        check(v, exp);
    endtask : rd_chk

    // Level inputs change just after an edge, then settle two edges
    task automatic set_lvl(input logic r, input logic c, input logic m);
        @(posedge clk_sys);
        #1;
        rst_n = r;
        ce = c;
        mem_space_en = m;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : set_lvl

    // ****
    // Scenarios
    // ****
    task automatic test_reset_values;
        rd_chk(PCH_OFF_MISC0, 32'h0000_0000);
        rd_chk(PCH_OFF_MISC3, 32'h3808_0100);
        rd_chk(PCH_OFF_CSR_MEM, 32'h0000_0008);
        rd_chk(PCH_OFF_CSR_IO, 32'h0000_0001);
        rd_chk(PCH_OFF_FLASH, 32'h0000_0000);
        rd_chk(PCH_OFF_ROM, 32'h0000_0000);
    endtask : test_reset_values

    // Size probe with all ones, then a plain pattern
    task automatic test_windows;
        wr(PCH_OFF_CSR_MEM, 4'hF, 32'hFFFF_FFFF);
        wr(PCH_OFF_CSR_IO, 4'hF, 32'hFFFF_FFFF);
        wr(PCH_OFF_FLASH, 4'hF, 32'hFFFF_FFFF);
        wr(PCH_OFF_ROM, 4'hF, 32'hFFFF_FFFF);
        rd_chk(PCH_OFF_CSR_MEM, 32'hFFFF_F008);
        rd_chk(PCH_OFF_CSR_IO, 32'hFFFF_FFE1);
        rd_chk(PCH_OFF_FLASH, 32'hFFF0_0000);
        rd_chk(PCH_OFF_ROM, 32'hFFF0_0001);
        check(bars.flash, 32'hFFF0_0000);
        check(bars.csr_mem, 32'hFFFF_F008);
        check(bars.csr_io, 32'hFFFF_FFE1);
        check(bars.rom, 32'hFFF0_0001);
        wr(PCH_OFF_CSR_MEM, 4'hF, 32'hA5A5_A5A5);
        wr(PCH_OFF_CSR_IO, 4'hF, 32'hA5A5_A5A5);
        rd_chk(PCH_OFF_CSR_MEM, 32'hA5A5_A008);
        rd_chk(PCH_OFF_CSR_IO, 32'hA5A5_A5A1);
    endtask : test_windows

    task automatic test_misc_bytes;
        wr(PCH_OFF_MISC0, 4'hF, 32'hFFFF_FFFF);
        rd_chk(PCH_OFF_MISC0, 32'h0000_FF00);
        check({24'h0, burst_latency_timer}, 32'h0000_00FF);
        wr(PCH_OFF_MISC0, 4'hD, 32'h0000_0000);
        rd_chk(PCH_OFF_MISC0, 32'h0000_FF00);
        wr(PCH_OFF_MISC3, 4'hF, 32'hFFFF_FFFF);
        rd_chk(PCH_OFF_MISC3, 32'h3808_01FF);
        wr(PCH_OFF_MISC3, 4'h1, 32'h0000_005A);
        rd_chk(PCH_OFF_MISC3, 32'h3808_015A);
        check({24'h0, interrupt_routing}, 32'h0000_005A);
        wr(PCH_OFF_MISC3, 4'hE, 32'h0000_0000);
        rd_chk(PCH_OFF_MISC3, 32'h3808_015A);
    endtask : test_misc_bytes

    task automatic test_reserved;
        for (int off = 8'h1C; off <= 8'h24; off += 4) begin
            wr(off[7:0], 4'hF, 32'hFFFF_FFFF);
            rd_chk(off[7:0], 32'h0000_0000);
        end
        rd_chk(PCH_OFF_FLASH, 32'hFFF0_0000);
    endtask : test_reserved

    // ROM enable is already set by the size probe
    task automatic test_rom_gate;
        check({31'h0, rom_decode_active}, 32'h0000_0000);
        set_lvl(1'b1, 1'b1, 1'b1);
        check({31'h0, rom_decode_active}, 32'h0000_0001);
        wr(PCH_OFF_ROM, 4'hF, 32'hFFF0_0000);
        set_lvl(1'b1, 1'b1, 1'b1);
        check({31'h0, rom_decode_active}, 32'h0000_0000);
    endtask : test_rom_gate

    // Frozen write, then a second reset in mid-run
    task automatic test_freeze_reset;
        set_lvl(1'b1, 1'b0, 1'b1);
        wr(PCH_OFF_MISC0, 4'hF, 32'h0000_3300);
        set_lvl(1'b1, 1'b1, 1'b1);
        rd_chk(PCH_OFF_MISC0, 32'h0000_FF00);
        set_lvl(1'b0, 1'b1, 1'b1);
        set_lvl(1'b1, 1'b1, 1'b1);
        rd_chk(PCH_OFF_MISC0, 32'h0000_0000);
        rd_chk(PCH_OFF_ROM, 32'h0000_0000);
    endtask : test_freeze_reset

    // ****
    // Sequence and verdict
    // ****
    task automatic results;
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // Reset held 16 cycles, then the scenarios in turn
    initial begin
        failures = 0;
        total_checks = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        mem_space_en = 1'b0;
        repeat (16) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        test_reset_values;
        test_windows;
        test_misc_bytes;
        test_reserved;
        test_rom_gate;
        test_freeze_reset;
        results;
    end

    // Whole run needs well under 1000 cycles
    initial begin
        #100000;
        failures++;
        results;
    end
endmodule : tb_top
